/* verilog/ucsr_regs.svh */
`ifndef UCSR_REGS_SVH
`define UCSR_REGS_SVH

`define UCSR_NUM_CFG      3
`define UCSR_NUM_MARK     4
`define UCSR_NUM_CONN     7
`define UCSR_DIR_RESET    2'h1
`define UCSR_SIG_RESET    3'h2
`define UCSR_TRIGSEL_INT  1'h0
`define UCSR_TRIGSEL_EXT  1'h1

`endif

/* verilog/ucsr_pkg.sv */
package ucsr_pkg;

	typedef enum logic [1:0] {
		UCSR_DIR_INPUT  = 2'h0,
		UCSR_DIR_OUTPUT = 2'h1,
		UCSR_DIR_UNUSED = 2'h2
	} ucsr_dir_t;

	typedef enum logic [2:0] {
		UCSR_SIG_GLOBAL_TRIG = 3'h0,
		UCSR_SIG_TRIGGERED   = 3'h1,
		UCSR_SIG_ALWAYS_LOW  = 3'h2,
		UCSR_SIG_ALWAYS_HIGH = 3'h3,
		UCSR_SIG_NONE        = 3'h4
	} ucsr_sig_t;

	typedef struct packed {
		ucsr_dir_t dir;
		ucsr_sig_t sig;
	} ucsr_conn_cfg_t;

	typedef struct packed {
		logic [2:0] oe;
		logic [2:0] dout;
		logic [3:0] marker;
	} ucsr_pins_t;

endpackage

/* verilog/ucsr_edge_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module ucsr_edge_sync
(
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic pin_in,
	input  wire logic fall_sel,
	output logic      level,
	output logic      pulse
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first stage is read only by the second
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			meta_q <= 1'h0;
			sync_q <= 1'h0;
			prev_q <= 1'h0;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	// one pulse per chosen edge
	assign pulse = fall_sel ? (prev_q & ~sync_q) : (~prev_q & sync_q);

endmodule // ucsr_edge_sync

`default_nettype wire

/* verilog/ucsr_router.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ucsr_regs.svh"

// Behaviour
// - connectors one to three each hold a direction: input (one and two only), output or unused
// - input set to global trigger forwards active edges as playback start
// - trigger-output connector drives internal trigger or copy of external trigger
// - constant types drive fixed low or fixed high
// - type none: driver disabled, input ignored
// - polarity setting picks rising or falling edge on connector one
// - only connectors one and two may be trigger inputs
// - after reset connectors one to three are outputs driving constant low
// - markers one to four drive connectors seven, six, five, four
module ucsr_router
(
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	input  wire logic                    cfg_we,
	input  wire logic [1:0]              cfg_idx,
	input  wire ucsr_pkg::ucsr_conn_cfg_t cfg_wdata,
	input  wire logic                    slope_fall,
	input  wire logic                    trig_out_sel,
	input  wire logic                    int_trig,
	input  wire logic [3:0]              marker_in,
	input  wire logic [2:0]              pin_in,
	output ucsr_pkg::ucsr_pins_t          pins,
	output logic                         play_start,
	output logic                         ext_trig_level,
	output ucsr_pkg::ucsr_conn_cfg_t      cfg_rd0,
	output ucsr_pkg::ucsr_conn_cfg_t      cfg_rd1,
	output ucsr_pkg::ucsr_conn_cfg_t      cfg_rd2
);
	import ucsr_pkg::*;

	ucsr_conn_cfg_t cfg_q [`UCSR_NUM_CFG];
	ucsr_pins_t     pins_q;
	logic [2:0]     oe_d;
	logic [2:0]     dout_d;
	logic [3:0]     marker_d;
	logic           start_q;
	logic           lvl_q;
	logic [1:0]     lvl;
	logic [1:0]     pls;
	logic [1:0]     arm;
	logic           ext_copy;

	// slope applies only to connector one; connector two is rising
	ucsr_edge_sync u_sync0
	(
		.sys_clk  (sys_clk),
		.reset    (reset),
		.pin_in   (pin_in[0]),
		.fall_sel (slope_fall),
		.level    (lvl[0]),
		.pulse    (pls[0])
	);

	ucsr_edge_sync u_sync1
	(
		.sys_clk  (sys_clk),
		.reset    (reset),
		.pin_in   (pin_in[1]),
		.fall_sel (1'h0),
		.level    (lvl[1]),
		.pulse    (pls[1])
	);

	// bad writes are dropped so the table never holds an illegal pairing
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < `UCSR_NUM_CFG; i++)
			begin
				cfg_q[i] <= '{dir: ucsr_dir_t'(`UCSR_DIR_RESET), sig: ucsr_sig_t'(`UCSR_SIG_RESET)};
			end
		end
		else if (cfg_we && cfg_idx < 2'h3)
		begin
			if (!(cfg_wdata.dir == UCSR_DIR_INPUT && cfg_idx == 2'h2))
				cfg_q[cfg_idx] <= cfg_wdata;
		end
	end

	always_comb
	begin
		for (int i = 0; i < 2; i++)
			arm[i] = cfg_q[i].dir == UCSR_DIR_INPUT && cfg_q[i].sig == UCSR_SIG_GLOBAL_TRIG;
	end

	assign ext_copy = (arm[0] & lvl[0]) | (arm[1] & lvl[1]);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			start_q <= 1'h0;
			lvl_q   <= 1'h0;
		end
		else
		begin
			start_q <= |(arm & pls);
			lvl_q   <= ext_copy;
		end
	end

	// enable and level are decoded apart so each has one driver per bit
	generate
		for (genvar g = 0; g < `UCSR_NUM_CFG; g++)
		begin : g_out
			// enable: only a driving output type turns the pin on
			always_comb
			begin
				oe_d[g] = 1'h0;
				if (cfg_q[g].dir == UCSR_DIR_OUTPUT)
				begin
					unique case (cfg_q[g].sig)
						UCSR_SIG_TRIGGERED:
						begin
							oe_d[g] = 1'h1;
						end
						UCSR_SIG_ALWAYS_LOW:
						begin
							oe_d[g] = 1'h1;
						end
						UCSR_SIG_ALWAYS_HIGH:
						begin
							oe_d[g] = 1'h1;
						end
						default:
						begin
							oe_d[g] = 1'h0;
						end
					endcase
				end
			end

			// level: held low whenever the driver is off, so no stale value shows
			always_comb
			begin
				dout_d[g] = 1'h0;
				if (cfg_q[g].dir == UCSR_DIR_OUTPUT)
				begin
					unique case (cfg_q[g].sig)
						UCSR_SIG_TRIGGERED:
						begin
							dout_d[g] = (trig_out_sel == `UCSR_TRIGSEL_EXT) ? ext_copy : int_trig;
						end
						UCSR_SIG_ALWAYS_LOW:
						begin
							dout_d[g] = 1'h0;
						end
						UCSR_SIG_ALWAYS_HIGH:
						begin
							dout_d[g] = 1'h1;
						end
						default:
						begin
							dout_d[g] = 1'h0;
						end
					endcase
				end
			end
		end
		for (genvar m = 0; m < `UCSR_NUM_MARK; m++)
		begin : g_mark
			// marker m+1 to connector 7-m; bit k of pins.marker is connector k+4
			assign marker_d[3 - m] = marker_in[m];
		end
	endgenerate

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			pins_q <= '{oe: 3'h7, dout: 3'h0, marker: 4'h0};
		else
			pins_q <= '{oe: oe_d, dout: dout_d, marker: marker_d};
	end

	assign pins           = pins_q;
	assign play_start     = start_q;
	assign ext_trig_level = lvl_q;
	assign cfg_rd0        = cfg_q[0];
	assign cfg_rd1        = cfg_q[1];
	assign cfg_rd2        = cfg_q[2];

endmodule // ucsr_router

`default_nettype wire

/* dv/ucsr_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module ucsr_checker
	import ucsr_pkg::*;
(
	input wire logic           sys_clk,
	input wire logic           reset,
	input wire ucsr_pins_t     pins,
	input wire logic           play_start,
	input wire logic [3:0]     marker_in,
	input wire ucsr_conn_cfg_t cfg_rd2
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	one_pulse_a: assert property(play_start|=>!play_start)else $error("bad");
	reset_out_a: assert property($past(reset)|->pins.oe==3'h7&&pins.dout==3'h0)else $error("bad");
	no_input_a: assert property(cfg_rd2.dir!=UCSR_DIR_INPUT)else $error("bad");
	const_out_a: assert property(cfg_rd2[4:1]==4'h5&&$stable(cfg_rd2)|->pins.dout[2]==cfg_rd2[0])
		else $error("bad");
	none_off_a: assert property(cfg_rd2.sig==UCSR_SIG_NONE&&$stable(cfg_rd2)|->!pins.oe[2])else $error("bad");
	marker_map_a: assert property(!$past(reset)|->pins.marker=={$past(marker_in[0]),$past(marker_in[1]),
		$past(marker_in[2]),$past(marker_in[3])})else $error("marker routing wrong");
endmodule // ucsr_checker
bind ucsr_router ucsr_checker u_chk(.sys_clk,.reset,.pins,.play_start,.marker_in,.cfg_rd2);
`default_nettype wire

/* dv/ucsr_ext_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module ucsr_ext_dev
(
	output logic [2:0] pin
);
	// idle low: inputs are pulled down
	initial pin=3'h0;
	task drive(input logic [2:0] v);
		pin=v;
	endtask
endmodule // ucsr_ext_dev
`default_nettype wire

/* dv/test_ucsr_router.sv */
`timescale 1ns/100ps
`default_nettype none
module test_ucsr_router;
	import ucsr_pkg::*;
	logic sys_clk=0,reset=1,cfg_we=0,slope_fall=0,trig_out_sel=0,int_trig=0,play_start,ext_lvl;
	logic [3:0] mk=4'h1;
	logic [1:0] cfg_idx=0;
	logic [2:0] pin_in;
	ucsr_conn_cfg_t cfg_wdata=0,cfg_rd2;
	ucsr_pins_t pins;
	int err_count=0,cmp_count=0,n;
	always #12.5 sys_clk=~sys_clk;
	always @(posedge sys_clk) n<=n+play_start;
	ucsr_router u_dut(.sys_clk,.reset,.cfg_we,.cfg_idx,.cfg_wdata,.slope_fall,.trig_out_sel,.int_trig,
		.marker_in(mk),.pin_in,.pins,.play_start,.ext_trig_level(ext_lvl),.cfg_rd0(),.cfg_rd1(),.cfg_rd2);
	ucsr_ext_dev u_ext(.pin(pin_in));
	task chk(input logic [7:0] g,e);
		cmp_count++;
		err_count+=g!==e;
		if(g!==e)
			$display("wrong value at %0t: %h %h",$time,g,e);
	endtask
	task cy(input int k);
		repeat(k)@(negedge sys_clk);
	endtask
	task wr(input logic [1:0] i,input logic [4:0] c);
		cfg_we=1;
		cfg_idx=i;
		cfg_wdata=c;
		cy(1);
		cfg_we=0;
		cy(2);
	endtask
	// pulses counted over a window wider than the sync delay
	task edg(input logic [2:0] v,input int e);
		u_ext.drive(v);
		n=0;
		cy(8);
		chk(n,e);
	endtask
	task t_out;
		wr(2,5'h0b);
		chk(pins.dout,3'h4);
		chk(pins.marker,4'h8);
		mk=4'h3;
		cy(2);
		chk(pins.marker,4'hc);
		wr(2,5'h00);
		chk(cfg_rd2,5'h0b);
		wr(2,5'h14);
		chk(pins.oe,3'h3);
		wr(2,5'h09);
		int_trig=1;
		cy(1);
		chk(pins.dout,3'h4);
	endtask
	task t_trig;
		wr(0,5'h00);
		trig_out_sel=1;
		edg(3'h1,1);
		chk(pins.dout[2],1'h1);
		chk(ext_lvl,1'h1);
		edg(3'h0,0);
		chk(ext_lvl,1'h0);
		slope_fall=1;
		edg(3'h1,0);
		edg(3'h0,1);
	endtask
	task results;
		$display("err %0d cmp %0d",err_count,cmp_count);
		if(err_count==0&&cmp_count>0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		cy(10);
		reset=0;
		t_out;
		t_trig;
		results;
	end
endmodule // test_ucsr_router
`default_nettype wire
